// file: rtl/metering_aux.sv
// Purpose: Line frequency, auxiliary channel results and metering controls
// Assumes: Samples arrive synchronous to clk with one-cycle valid strobes
// Notes: Update intervals are counted in samples, so they follow the ADC rate
//
// Contract
// - Band-pass filter voltage, detect crossings, store average samples over sixteen cycles.
// - Frequency result is sixteen-bit unsigned, cleared by every reset source.
// - Resolution 0.05 Hz per count over 35 to 75 Hz span; the code stores the sixteen-cycle average of samples per cycle instead.
// - At nominal clock, frequency refreshes every 320 ms, settled after 500 ms.
// - At reduced clock, band-pass samples slower with lower centre, accuracy degrades.
// - Raw, instantaneous DC and average DC results, 32-bit signed, reset cleared.
// - Raw refreshes 0.3 ms, instantaneous 20 ms, average 1.28 s at nominal clock.
// - Slower clock by K stretches every update and settle time by K.
// - Source select bits 2:0, code 001 temperature; divider bit 4 clear.
// - Chop-off bit 0 set stops auxiliary DC offset removal.
// - Gate bit 7 clear enables sampling and power and RMS circuits.
// - Bit 3 feeds auxiliary samples, bit 4 enables processing.
// - Software programs calibration, channel select, phase, filter, pulse, no-load, inputs.
`timescale 1ns/10ps
module metering_aux #(
    parameter int SAMPLE_W = 24,
    parameter int INST_LOG2 = 6,
    parameter int AVG_LOG2 = 6
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic voltageValid,
    input wire logic signed [SAMPLE_W-1:0] voltageSample,
    input wire logic auxValid,
    input wire logic signed [SAMPLE_W-1:0] auxSample,
    input wire logic [1:0] creepStatus,
    output logic [2:0] auxSourceSelect,
    output logic dividerEnable,
    output logic dividerAltEnable,
    output logic auxAdcPowerUp,
    output logic samplingGate,
    output logic [7:0] processingCtrl,
    output logic [7:0] filterPathCtrl,
    output logic [7:0] accumulationCtrl,
    output logic [7:0] pulseOutputCtrl,
    output logic [15:0] phaseCompCtrl,
    output logic [3:0] phaseCompSel,
    output logic [31:0] bandpassCoefficient
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] srcCtrl_r, pwrCtrl_r, chopCtrl_r, procCtrl_r, filtCtrl_r;
    logic [7:0] phaCtrl_r, phbCtrl_r, accCtrl_r, pulseCtrl_r, creepCtrl_r, gateCtrl_r;
    logic [31:0] coef_r, raw_r, inst_r, avg_r, prdata_r;
    logic [15:0] freq_r;
    logic slverr_r;

    // Decoded bus access
    logic [13:0] idx;
    logic aligned, setupCyc, accessCyc, wrEn;
    assign idx = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setupCyc = psel && !penable;
    assign accessCyc = psel && penable;
    assign wrEn = accessCyc && pwrite && !slverr_r;

    // Local copies of the register indices, declared before the decoders use them
    localparam logic [13:0] IDX_RAW_L = metering_aux_pkg::IDX_RAW;
    localparam logic [13:0] IDX_INST_L = metering_aux_pkg::IDX_INST;
    localparam logic [13:0] IDX_AVG_L = metering_aux_pkg::IDX_AVG;
    localparam logic [13:0] IDX_COEF_L = metering_aux_pkg::IDX_COEF;
    localparam logic [13:0] IDX_FREQ_L = metering_aux_pkg::IDX_FREQ;
    localparam logic [13:0] IDX_SRC_L = metering_aux_pkg::IDX_SRC;
    localparam logic [13:0] IDX_PWR_L = metering_aux_pkg::IDX_PWR;
    localparam logic [13:0] IDX_CHOP_L = metering_aux_pkg::IDX_CHOP;
    localparam logic [13:0] IDX_PROC_L = metering_aux_pkg::IDX_PROC;
    localparam logic [13:0] IDX_FILT_L = metering_aux_pkg::IDX_FILT;
    localparam logic [13:0] IDX_PHA_L = metering_aux_pkg::IDX_PHA;
    localparam logic [13:0] IDX_PHB_L = metering_aux_pkg::IDX_PHB;
    localparam logic [13:0] IDX_ACC_L = metering_aux_pkg::IDX_ACC;
    localparam logic [13:0] IDX_PULSE_L = metering_aux_pkg::IDX_PULSE;
    localparam logic [13:0] IDX_CREEP_L = metering_aux_pkg::IDX_CREEP;
    localparam logic [13:0] IDX_GATE_L = metering_aux_pkg::IDX_GATE;

    // Returns one for an index that holds a register
    function automatic logic isMapped(input logic [13:0] i);
        case (i)
            IDX_RAW_L, IDX_INST_L, IDX_AVG_L, IDX_COEF_L, IDX_FREQ_L, IDX_SRC_L, IDX_PWR_L, IDX_CHOP_L,
            IDX_PROC_L, IDX_FILT_L, IDX_PHA_L, IDX_PHB_L, IDX_ACC_L, IDX_PULSE_L, IDX_CREEP_L,
            IDX_GATE_L: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Returns one for a result register that software cannot write
    function automatic logic isReadOnly(input logic [13:0] i);
        isReadOnly = (i == IDX_RAW_L) || (i == IDX_INST_L) || (i == IDX_AVG_L) || (i == IDX_FREQ_L);
    endfunction

    // ----------------------------------------------------------------
    // APB slave: read data and error captured in the setup cycle
    // ----------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        case (idx)
            IDX_RAW_L: rdMux = raw_r;
            IDX_INST_L: rdMux = inst_r;
            IDX_AVG_L: rdMux = avg_r;
            IDX_COEF_L: rdMux = coef_r;
            IDX_FREQ_L: rdMux = {16'h0000, freq_r};
            IDX_SRC_L: rdMux = {24'h000000, srcCtrl_r};
            IDX_PWR_L: rdMux = {24'h000000, pwrCtrl_r};
            IDX_CHOP_L: rdMux = {24'h000000, chopCtrl_r};
            IDX_PROC_L: rdMux = {24'h000000, procCtrl_r};
            IDX_FILT_L: rdMux = {24'h000000, filtCtrl_r};
            IDX_PHA_L: rdMux = {24'h000000, phaCtrl_r};
            IDX_PHB_L: rdMux = {24'h000000, phbCtrl_r};
            IDX_ACC_L: rdMux = {24'h000000, accCtrl_r};
            IDX_PULSE_L: rdMux = {24'h000000, pulseCtrl_r};
            IDX_CREEP_L: rdMux = {24'h000000, creepStatus, creepCtrl_r[5:0]};
            IDX_GATE_L: rdMux = {24'h000000, gateCtrl_r};
            default: rdMux = 32'h00000000;
        endcase
    end

    // Capture answer for the following access cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
        end else if (setupCyc) begin
            prdata_r <= (aligned && isMapped(idx) && !pwrite) ? rdMux : 32'h00000000;
            slverr_r <= !aligned || !isMapped(idx) || (pwrite && isReadOnly(idx));
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = accessCyc && slverr_r;

    // Control register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            srcCtrl_r <= metering_aux_pkg::CTRL_RST;
            pwrCtrl_r <= metering_aux_pkg::CTRL_RST;
            chopCtrl_r <= metering_aux_pkg::CTRL_RST;
            procCtrl_r <= metering_aux_pkg::CTRL_RST;
            filtCtrl_r <= metering_aux_pkg::CTRL_RST;
            phaCtrl_r <= metering_aux_pkg::CTRL_RST;
            phbCtrl_r <= metering_aux_pkg::CTRL_RST;
            accCtrl_r <= metering_aux_pkg::CTRL_RST;
            pulseCtrl_r <= metering_aux_pkg::CTRL_RST;
            creepCtrl_r <= metering_aux_pkg::CTRL_RST;
            gateCtrl_r <= metering_aux_pkg::GATE_RST;
            coef_r <= metering_aux_pkg::COEF_RST;
        end else if (wrEn) begin
            case (idx)
                IDX_SRC_L: srcCtrl_r <= pwdata[7:0];
                IDX_PWR_L: pwrCtrl_r <= pwdata[7:0];
                IDX_CHOP_L: chopCtrl_r <= pwdata[7:0];
                IDX_PROC_L: procCtrl_r <= pwdata[7:0];
                IDX_FILT_L: filtCtrl_r <= pwdata[7:0];
                IDX_PHA_L: phaCtrl_r <= pwdata[7:0];
                IDX_PHB_L: phbCtrl_r <= pwdata[7:0];
                IDX_ACC_L: accCtrl_r <= pwdata[7:0];
                IDX_PULSE_L: pulseCtrl_r <= pwdata[7:0];
                IDX_CREEP_L: creepCtrl_r <= {2'h0, pwdata[5:0]};
                IDX_GATE_L: gateCtrl_r <= pwdata[7:0];
                IDX_COEF_L: coef_r <= pwdata;
                default: coef_r <= coef_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    logic procOn, auxOn, bpfOn, chopOff;
    assign samplingGate = gateCtrl_r[metering_aux_pkg::GATE_BIT];
    assign procOn = !samplingGate && procCtrl_r[metering_aux_pkg::PROC_EN_BIT];
    assign auxOn = procOn && procCtrl_r[metering_aux_pkg::AUX_IN_BIT] && auxAdcPowerUp;
    assign bpfOn = filtCtrl_r[metering_aux_pkg::BPF_EN_BIT];
    assign chopOff = chopCtrl_r[metering_aux_pkg::CHOP_OFF_BIT];
    assign auxSourceSelect = srcCtrl_r[metering_aux_pkg::SRC_SEL_LSB +: 3];
    assign dividerEnable = srcCtrl_r[metering_aux_pkg::DIV_BIT];
    assign dividerAltEnable = srcCtrl_r[metering_aux_pkg::DIV_ALT_BIT];
    assign auxAdcPowerUp = pwrCtrl_r[metering_aux_pkg::PWR_UP_BIT];
    assign processingCtrl = procCtrl_r;
    assign filterPathCtrl = filtCtrl_r;
    assign accumulationCtrl = accCtrl_r;
    assign pulseOutputCtrl = pulseCtrl_r;
    assign phaseCompCtrl = {phbCtrl_r, phaCtrl_r};
    assign phaseCompSel = creepCtrl_r[3:0];
    assign bandpassCoefficient = coef_r;

    // ----------------------------------------------------------------
    // Line frequency: band-pass as difference of two low-pass stages
    // ----------------------------------------------------------------
    logic signed [31:0] vIn, lpFast_r, lpSlow_r, bandOut;
    logic prevNeg_r, armed_r, crossing;
    logic [15:0] period_r;
    logic [19:0] periodSum_r;
    logic [4:0] cycleCnt_r;
    assign vIn = 32'(voltageSample);
    assign bandOut = bpfOn ? (lpFast_r - lpSlow_r) : vIn;
    assign crossing = voltageValid && procOn && prevNeg_r && !bandOut[31];

    // Filter poles; pole spacing tracks the sample rate, so a slow clock moves the centre down
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lpFast_r <= 32'sh00000000;
            lpSlow_r <= 32'sh00000000;
            prevNeg_r <= 1'b0;
        end else if (voltageValid && procOn) begin
            lpFast_r <= lpFast_r + ((vIn - lpFast_r) >>> metering_aux_pkg::FAST_SHIFT);
            lpSlow_r <= lpSlow_r + ((lpFast_r - lpSlow_r) >>> metering_aux_pkg::SLOW_SHIFT);
            prevNeg_r <= bandOut[31];
        end
    end

    // Count samples per cycle and average over sixteen cycles
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_r <= 16'h0000;
            periodSum_r <= 20'h00000;
            cycleCnt_r <= 5'h00;
            armed_r <= 1'b0;
            freq_r <= metering_aux_pkg::FREQ_RST;
        end else if (!procOn) begin
            armed_r <= 1'b0;
            cycleCnt_r <= 5'h00;
            periodSum_r <= 20'h00000;
        end else if (crossing) begin
            period_r <= 16'h0001;
            armed_r <= 1'b1;
            if (armed_r) begin
                if (cycleCnt_r == metering_aux_pkg::FREQ_CYCLES - 5'h01) begin
                    freq_r <= 16'((periodSum_r + 20'(period_r)) >> metering_aux_pkg::FREQ_LOG2);
                    periodSum_r <= 20'h00000;
                    cycleCnt_r <= 5'h00;
                end else begin
                    periodSum_r <= periodSum_r + 20'(period_r);
                    cycleCnt_r <= cycleCnt_r + 5'h01;
                end
            end
        end else if (voltageValid && period_r != 16'hFFFF) begin
            period_r <= period_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Auxiliary channel: raw, instantaneous DC, average DC
    // ----------------------------------------------------------------
    logic signed [31:0] aIn;
    logic signed [INST_LOG2+31:0] instSum_r;
    logic signed [AVG_LOG2+31:0] avgSum_r;
    logic [INST_LOG2-1:0] instCnt_r;
    logic [AVG_LOG2-1:0] avgCnt_r;
    logic auxTake, instDone;
    assign aIn = 32'(auxSample);
    assign auxTake = auxValid && auxOn;
    assign instDone = auxTake && (instCnt_r == {INST_LOG2{1'b1}});
    // Block result as it completes; the average takes it at once so it does not lag one block
    logic signed [31:0] instNext;
    assign instNext = 32'((instSum_r + (INST_LOG2+32)'(aIn)) >>> INST_LOG2);

    // Raw waveform, offset removed unless chop-off is set
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            raw_r <= metering_aux_pkg::RESULT_RST;
        end else if (auxTake) begin
            raw_r <= chopOff ? aIn : aIn - inst_r;
        end
    end

    // Block average of auxiliary input samples, before offset removal
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            instSum_r <= '0;
            instCnt_r <= '0;
            inst_r <= metering_aux_pkg::RESULT_RST;
        end else if (auxTake) begin
            instCnt_r <= instCnt_r + 1'b1;
            if (instDone) begin
                inst_r <= instNext;
                instSum_r <= '0;
            end else begin
                instSum_r <= instSum_r + (INST_LOG2+32)'(aIn);
            end
        end
    end

    // Average of instantaneous DC results
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avgSum_r <= '0;
            avgCnt_r <= '0;
            avg_r <= metering_aux_pkg::RESULT_RST;
        end else if (instDone) begin
            avgCnt_r <= avgCnt_r + 1'b1;
            if (avgCnt_r == {AVG_LOG2{1'b1}}) begin
                avg_r <= 32'((avgSum_r + (AVG_LOG2+32)'(instNext)) >>> AVG_LOG2);
                avgSum_r <= '0;
            end else begin
                avgSum_r <= avgSum_r + (AVG_LOG2+32)'(instNext);
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_unmapped_err: assert property (@(posedge clk) disable iff (!reset_n)
        setupCyc && !isMapped(idx) |=> pslverr) else $error("unmapped access not flagged");
    chk_coef_write: assert property (@(posedge clk) disable iff (!reset_n)
        wrEn && idx == IDX_COEF_L |=> coef_r == $past(pwdata)) else $error("coefficient not stored");
    chk_ro_protect: assert property (@(posedge clk) disable iff (!reset_n)
        accessCyc && pwrite && isReadOnly(idx) |-> pslverr) else $error("result write not refused");
    chk_gate_block: assert property (@(posedge clk) disable iff (!reset_n)
        samplingGate |=> $stable(raw_r) && $stable(freq_r)) else $error("gated block updated");
    chk_chop_bypass: assert property (@(posedge clk) disable iff (!reset_n)
        auxTake && chopOff |=> raw_r == $past(aIn)) else $error("raw not taken as is");
    chk_aux_input: assert property (@(posedge clk) disable iff (!reset_n)
        !procCtrl_r[metering_aux_pkg::AUX_IN_BIT] |=> $stable(raw_r)) else $error("aux ran disabled");
    chk_freq_cycles: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(freq_r) |-> $past(cycleCnt_r) == metering_aux_pkg::FREQ_CYCLES - 5'h01)
        else $error("frequency update off cycle");
    chk_inst_rate: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(inst_r) |-> $past(instDone)) else $error("instant DC off block");
    chk_avg_rate: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(avg_r) |-> $past(instDone) && $past(avgCnt_r) == {AVG_LOG2{1'b1}})
        else $error("average DC off block");
    chk_source_out: assert property (@(posedge clk) disable iff (!reset_n)
        wrEn && idx == IDX_SRC_L |=> auxSourceSelect == $past(pwdata[2:0])) else $error("source not driven");

    // Reset values and datapath steps
    chk_reset_freq: assert property (@(posedge clk)
        !reset_n |=> freq_r == metering_aux_pkg::FREQ_RST) else $error("frequency not cleared by reset");
    chk_reset_results: assert property (@(posedge clk)
        !reset_n |=> raw_r == metering_aux_pkg::RESULT_RST && inst_r == metering_aux_pkg::RESULT_RST
        && avg_r == metering_aux_pkg::RESULT_RST) else $error("results not cleared by reset");
    chk_raw_offset: assert property (@(posedge clk) disable iff (!reset_n)
        auxTake && !chopOff |=> raw_r == $past(aIn) - $past(inst_r)) else $error("offset not removed");
    chk_aux_power: assert property (@(posedge clk) disable iff (!reset_n)
        !auxAdcPowerUp |=> $stable(raw_r) && $stable(inst_r)) else $error("aux ran powered down");
    chk_freq_gated: assert property (@(posedge clk) disable iff (!reset_n)
        !procOn |=> cycleCnt_r == 5'h00) else $error("cycle count kept while off");
    chk_period_count: assert property (@(posedge clk) disable iff (!reset_n)
        voltageValid && procOn && !crossing && period_r != 16'hFFFF |=> period_r == $past(period_r) + 16'h0001)
        else $error("sample count not advanced");
    chk_period_restart: assert property (@(posedge clk) disable iff (!reset_n)
        crossing |=> period_r == 16'h0001) else $error("sample count not restarted");
    chk_phase_write: assert property (@(posedge clk) disable iff (!reset_n)
        wrEn && idx == IDX_PHA_L |=> phaseCompCtrl[7:0] == $past(pwdata[7:0])) else $error("phase not driven");
    chk_gate_write: assert property (@(posedge clk) disable iff (!reset_n)
        wrEn && idx == IDX_GATE_L |=> samplingGate == $past(pwdata[7])) else $error("gate not driven");
    chk_chop_write: assert property (@(posedge clk) disable iff (!reset_n)
        wrEn && idx == IDX_CHOP_L |=> chopOff == $past(pwdata[0])) else $error("chop control not driven");
endmodule

// file: rtl/metering_aux_pkg.sv
// Purpose: Shared constants for the auxiliary measurement block
// Assumes: Register index times four gives the APB byte address
// Notes: Eight-bit registers sit in the low byte, upper bits read zero
package metering_aux_pkg;
    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [13:0] IDX_RAW = 14'h10CE;
    localparam logic [13:0] IDX_INST = 14'h10CF;
    localparam logic [13:0] IDX_AVG = 14'h10D0;
    localparam logic [13:0] IDX_COEF = 14'h10EF;
    localparam logic [13:0] IDX_FREQ = 14'h10FD;
    localparam logic [13:0] IDX_SRC = 14'h2863;
    localparam logic [13:0] IDX_PWR = 14'h2864;
    localparam logic [13:0] IDX_CHOP = 14'h2865;
    localparam logic [13:0] IDX_PROC = 14'h2878;
    localparam logic [13:0] IDX_FILT = 14'h287A;
    localparam logic [13:0] IDX_PHA = 14'h287B;
    localparam logic [13:0] IDX_PHB = 14'h287C;
    localparam logic [13:0] IDX_ACC = 14'h287D;
    localparam logic [13:0] IDX_PULSE = 14'h287E;
    localparam logic [13:0] IDX_CREEP = 14'h287F;
    localparam logic [13:0] IDX_GATE = 14'h2886;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SRC_SEL_LSB = 0;
    localparam int DIV_BIT = 4;
    localparam int DIV_ALT_BIT = 5;
    localparam int PWR_UP_BIT = 3;
    localparam int CHOP_OFF_BIT = 0;
    localparam int GATE_BIT = 7;
    localparam int AUX_IN_BIT = 3;
    localparam int PROC_EN_BIT = 4;
    localparam int BPF_EN_BIT = 6;
    localparam int CREEP_ST_LSB = 6;
    // ----------------------------------------------------------------
    // Values after reset, and the temperature source select code
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GATE_RST = 8'h80;
    localparam logic [31:0] COEF_RST = 32'h00000000;
    localparam logic [31:0] RESULT_RST = 32'h00000000;
    localparam logic [15:0] FREQ_RST = 16'h0000;
    localparam logic [3:0] SRC_TEMPERATURE = 4'h1;
    // ----------------------------------------------------------------
    // Counts
    // ----------------------------------------------------------------
    localparam int FREQ_LOG2 = 4;
    localparam logic [4:0] FREQ_CYCLES = 5'h10;
    localparam int FAST_SHIFT = 2;
    localparam int SLOW_SHIFT = 5;
endpackage

// file: tb/testbench.sv
// Purpose: Self-checking bench for the auxiliary measurement block
// Assumes: APB slave answers with pready, bench drives all inputs on rising edges
// Notes: Short averaging counts (4 samples) keep the run brief
`timescale 1ns/10ps
`define CHECK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, voltageValid = 1'b0, auxValid = 1'b0, dividerEnable, dividerAltEnable;
    logic signed [23:0] voltageSample = 24'h000000, auxSample = 24'h000000;
    logic [1:0] creepStatus = 2'h2;
    logic [2:0] auxSourceSelect;
    logic auxAdcPowerUp, samplingGate;
    logic [7:0] processingCtrl, filterPathCtrl, accumulationCtrl, pulseOutputCtrl;
    logic [15:0] phaseCompCtrl;
    logic [3:0] phaseCompSel;
    logic [31:0] bandpassCoefficient;
    int miscompares = 0, samplesChecked = 0;
    // ------------------------------------------------------------
    // Device under test
    // ------------------------------------------------------------
    metering_aux #(.SAMPLE_W(24), .INST_LOG2(2), .AVG_LOG2(2)) metering_aux_i (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .voltageValid(voltageValid),
        .voltageSample(voltageSample), .auxValid(auxValid), .auxSample(auxSample), .creepStatus(creepStatus),
        .auxSourceSelect(auxSourceSelect), .dividerEnable(dividerEnable), .dividerAltEnable(dividerAltEnable),
        .auxAdcPowerUp(auxAdcPowerUp), .samplingGate(samplingGate), .processingCtrl(processingCtrl),
        .filterPathCtrl(filterPathCtrl), .accumulationCtrl(accumulationCtrl), .pulseOutputCtrl(pulseOutputCtrl),
        .phaseCompCtrl(phaseCompCtrl), .phaseCompSel(phaseCompSel), .bandpassCoefficient(bandpassCoefficient));
    // Clock at 20 MHz
    initial begin
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus and sample tasks
    // ------------------------------------------------------------
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One APB transfer, held until pready is seen
    task automatic apbXfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                           output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tallyAndFinish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a write has landed before the caller looks at outputs
        @(posedge clk);
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] wd, input logic expErr);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b1, idx, wd, rd, err);
        `CHECK(err, expErr)
    endtask
    task automatic rdChk(input logic [13:0] idx, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b0, idx, 32'h00000000, rd, err);
        `CHECK(err, expErr)
        `CHECK(rd, exp)
    endtask
    // Single auxiliary sample strobe
    task automatic aux(input logic [23:0] v);
        @(posedge clk);
        auxValid <= 1'b1;
        auxSample <= v;
        @(posedge clk);
        auxValid <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // Reset defaults and refused accesses
        rdChk(metering_aux_pkg::IDX_GATE, 32'h00000080, 1'b0);
        rdChk(metering_aux_pkg::IDX_FREQ, 32'h00000000, 1'b0);
        rdChk(metering_aux_pkg::IDX_AVG, 32'h00000000, 1'b0);
        wr(metering_aux_pkg::IDX_RAW, 32'h12345678, 1'b1);
        rdChk(14'h0001, 32'h00000000, 1'b1);
        wr(metering_aux_pkg::IDX_ACC, 32'h00000000, 1'b0);
        wr(metering_aux_pkg::IDX_PROC, 32'h00000000, 1'b0);
        // Control registers and their outputs
        wr(metering_aux_pkg::IDX_SRC, 32'h00000032, 1'b0);
        `CHECK({auxSourceSelect, dividerEnable, dividerAltEnable}, 5'b01011)
        wr(metering_aux_pkg::IDX_SRC, {28'h0000000, metering_aux_pkg::SRC_TEMPERATURE}, 1'b0);
        `CHECK({auxSourceSelect, dividerEnable}, 4'h2)
        wr(metering_aux_pkg::IDX_COEF, 32'h911D3C9C, 1'b0);
        rdChk(metering_aux_pkg::IDX_COEF, 32'h911D3C9C, 1'b0);
        wr(metering_aux_pkg::IDX_PHA, 32'h0000005A, 1'b0);
        wr(metering_aux_pkg::IDX_PHB, 32'h000000A5, 1'b0);
        wr(metering_aux_pkg::IDX_CREEP, 32'h000000FF, 1'b0);
        rdChk(metering_aux_pkg::IDX_CREEP, 32'h000000BF, 1'b0);
        `CHECK({phaseCompCtrl, phaseCompSel, bandpassCoefficient}, {16'hA55A, 4'hF, 32'h911D3C9C})
        wr(metering_aux_pkg::IDX_ACC, 32'h00000038, 1'b0);
        wr(metering_aux_pkg::IDX_PULSE, 32'h00000050, 1'b0);
        wr(metering_aux_pkg::IDX_FILT, 32'h00000020, 1'b0);
        `CHECK({accumulationCtrl, pulseOutputCtrl, filterPathCtrl}, 24'h385020)
        rdChk(metering_aux_pkg::IDX_PULSE, 32'h00000050, 1'b0);
        // Processing on with chop off
        wr(metering_aux_pkg::IDX_PWR, 32'h00000008, 1'b0);
        wr(metering_aux_pkg::IDX_CHOP, 32'h00000001, 1'b0);
        wr(metering_aux_pkg::IDX_GATE, 32'h00000000, 1'b0);
        wr(metering_aux_pkg::IDX_PROC, 32'h00000018, 1'b0);
        `CHECK({auxAdcPowerUp, samplingGate, processingCtrl}, 10'h218)
        rdChk(metering_aux_pkg::IDX_RAW, 32'h00000000, 1'b0);
        // Sixteen equal samples fill four instant blocks and one average
        repeat (16) aux(24'h000400);
        rdChk(metering_aux_pkg::IDX_RAW, 32'h00000400, 1'b0);
        rdChk(metering_aux_pkg::IDX_INST, 32'h00000400, 1'b0);
        rdChk(metering_aux_pkg::IDX_AVG, 32'h00000400, 1'b0);
        aux(24'hFFF000);
        rdChk(metering_aux_pkg::IDX_RAW, 32'hFFFFF000, 1'b0);
        // Offset removal back on: raw is sample minus instant level
        wr(metering_aux_pkg::IDX_CHOP, 32'h00000000, 1'b0);
        aux(24'h000500);
        rdChk(metering_aux_pkg::IDX_RAW, 32'h00000100, 1'b0);
        // Square wave of twenty samples per period
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            voltageValid <= 1'b1;
            voltageSample <= ((i % 20) < 10) ? -24'sd1000 : 24'sd1000;
        end
        @(posedge clk);
        voltageValid <= 1'b0;
        rdChk(metering_aux_pkg::IDX_FREQ, 32'h00000014, 1'b0);
        // Sampling gated: samples are ignored
        wr(metering_aux_pkg::IDX_GATE, 32'h00000080, 1'b0);
        aux(24'h000700);
        rdChk(metering_aux_pkg::IDX_RAW, 32'h00000100, 1'b0);
        `CHECK(samplingGate, 1'b1)
        tallyAndFinish();
    end
endmodule
